// [hw/count_prescaler.sv]
// count_prescaler: makes the one-cycle count enable from pclk
// assumes hold is driven on the same clock by the timer core
module count_prescaler
  import pulse_timer_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       run,
  input  wire logic       hold,
  input  wire logic [1:0] clock_sel,
  // enable out
  output logic            tick
);
  // ---------------------------------------------------------------
  // divider
  // ---------------------------------------------------------------
  logic [7:0] div_count;
  logic [7:0] div_limit;
  logic       wrap;

  assign div_limit = (clock_sel == 2'h0) ? 8'h00 : (clock_sel == 2'h1) ? div_fast : div_slow;
  assign wrap      = (div_count >= div_limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_count <= 8'h00;
      tick      <= 1'b0;
    end else if (!run) begin
      div_count <= 8'h00;
      tick      <= 1'b0;
    end else if (hold) begin
      // counts are held back, not dropped
      tick      <= 1'b0;
    end else begin
      div_count <= wrap ? 8'h00 : div_count + 8'h01;
      tick      <= wrap;
    end
  end
endmodule

// [hw/pulse_timer_pkg.sv]
// pulse_timer_pkg: register map, field positions, reset values and timing constants
// assumes a 40 MHz apb clock and a 32-bit apb bus
package pulse_timer_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] off_up_counter      = 8'h00;
  localparam logic [7:0] off_period_compare  = 8'h04;
  localparam logic [7:0] off_width_compare   = 8'h08;
  localparam logic [7:0] off_mode_control    = 8'h0c;
  localparam logic [7:0] off_capture_compare = 8'h10;
  localparam logic [7:0] off_output_control  = 8'h14;
  localparam logic [7:0] off_prescaler_mode  = 8'h18;
  // ---------------------------------------------------------------
  // mode control fields
  // ---------------------------------------------------------------
  localparam int          pos_overflow_flag = 0;
  localparam int          pos_run_mode_lo   = 2;
  localparam int          pos_run_mode_hi   = 3;
  localparam logic [1:0]  run_stop          = 2'h0;
  localparam logic [1:0]  run_edge_restart  = 2'h1;
  localparam logic [1:0]  run_free          = 2'h2;
  localparam logic [1:0]  run_period_clear  = 2'h3;
  // ---------------------------------------------------------------
  // output control fields
  // ---------------------------------------------------------------
  localparam int pos_output_enable      = 0;
  localparam int pos_period_toggle      = 1;
  localparam int pos_output_level_reset = 2;
  localparam int pos_output_level_set   = 3;
  localparam int pos_width_toggle       = 4;
  localparam int pos_oneshot_mode       = 5;
  localparam int pos_oneshot_trigger    = 6;
  localparam logic [7:0] output_ctrl_read_mask = 8'h33;
  // ---------------------------------------------------------------
  // prescaler fields
  // ---------------------------------------------------------------
  localparam int pos_clock_sel    = 0;
  localparam int pos_edge_sel_lo  = 4;
  localparam int pos_edge_sel_hi  = 5;
  localparam logic [1:0] edge_fall = 2'h0;
  localparam logic [1:0] edge_rise = 2'h1;
  localparam logic [1:0] edge_both = 2'h3;
  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [15:0] rst_compare   = 16'h0000;
  localparam logic [7:0]  rst_control   = 8'h00;
  localparam logic [15:0] counter_max   = 16'hffff;
  localparam int          pclk_mhz      = 40;
  localparam int          read_hold_ns  = 25;
  localparam int          read_hold_cyc = (read_hold_ns * pclk_mhz + 999) / 1000;
  localparam logic [7:0]  div_fast      = 8'h03;
  localparam logic [7:0]  div_slow      = 8'hff;
endpackage

// [hw/timer_pulse_oneshot_output.sv]
// timer_pulse_oneshot_output: 16-bit timer with programmable pulse and one-shot output
// assumes an apb master on pclk and an asynchronous trigger pin
//
// Notes on behaviour
// - pulse period is period compare plus one, width is width compare plus one
// - in pulse mode counter clears and restarts on period compare match
// - one-shot output launched by software bit or by trigger pin edge
// - writing one to output control bit 6 launches a one-shot pulse
// - trigger clears and starts counter; active at width, inactive at period
// - if width exceeds period roles swap; equal values are not allowed
// - counter keeps running after one-shot until run bits go to stop
// - trigger edge selects rising, falling or both via prescaler bits 4 and 5
// - trigger pin still clears and starts in software one-shot mode
// - counter runs as soon as run bits leave stop, stops on zero
// - start is aligned to count clock; divider is cleared while stopped, so first tick comes a fixed delay after start
// - counter read holds the count clock briefly; no copy to width register
// - stopped counter ignores pin activity and raises no events
// - zero compare matches on step zero to one after overflow
// - compare written below count is reached only after overflow or a counter clear
// - trigger, level set and level reset bits always read zero
module timer_pulse_oneshot_output
  import pulse_timer_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // pins
  input  wire logic        trigger_input_pin,
  output logic             pulse_output_pin,
  // events
  output logic             compare_match_irq
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [15:0] up_counter;
  logic [15:0] period_compare_reg;
  logic [15:0] width_compare_reg;
  logic [7:0]  mode_control_reg;
  logic [7:0]  capture_compare_ctrl_reg;
  logic [7:0]  output_control_reg;
  logic [7:0]  prescaler_mode_reg;
  logic        zero_armed;
  logic        read_hold;
  logic        tick;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  wire        setup_phase = psel && !penable;
  wire        access      = psel && penable;
  wire        wr          = access && pwrite;
  wire        mapped      = hit(paddr, off_up_counter) || hit(paddr, off_period_compare) ||
                            hit(paddr, off_width_compare) || hit(paddr, off_mode_control) ||
                            hit(paddr, off_capture_compare) || hit(paddr, off_output_control) ||
                            hit(paddr, off_prescaler_mode);
  wire        wr_period   = wr && hit(paddr, off_period_compare);
  wire        wr_width    = wr && hit(paddr, off_width_compare);
  wire        wr_mode     = wr && hit(paddr, off_mode_control);
  wire        wr_capture  = wr && hit(paddr, off_capture_compare);
  wire        wr_output   = wr && hit(paddr, off_output_control);
  wire        wr_prescale = wr && hit(paddr, off_prescaler_mode);
  wire        rd_counter  = setup_phase && !pwrite && hit(paddr, off_up_counter);
  wire        soft_trig   = wr_output && pwdata[pos_oneshot_trigger];

  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  wire [1:0]  run_mode      = {mode_control_reg[pos_run_mode_hi], mode_control_reg[pos_run_mode_lo]};
  wire        running       = (run_mode != run_stop);
  wire        period_mode   = (run_mode == run_period_clear);
  wire        edge_mode     = (run_mode == run_edge_restart);
  wire [1:0]  edge_sel      = {prescaler_mode_reg[pos_edge_sel_hi], prescaler_mode_reg[pos_edge_sel_lo]};
  wire        out_enable    = output_control_reg[pos_output_enable];
  wire        period_toggle = output_control_reg[pos_period_toggle];
  wire        width_toggle  = output_control_reg[pos_width_toggle];
  wire        oneshot_mode  = output_control_reg[pos_oneshot_mode];

  // ---------------------------------------------------------------
  // trigger pin synchroniser and edge detect
  // ---------------------------------------------------------------
  logic [2:0] trig_sync;
  logic       trig_level;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_sync <= 3'h0;
    end else begin
      trig_sync <= {trig_sync[1:0], trigger_input_pin};
    end
  end

  wire trig_agree = (trig_sync[2] == trig_sync[1]);
  wire trig_rise  = trig_agree && trig_sync[1] && !trig_level;
  wire trig_fall  = trig_agree && !trig_sync[1] && trig_level;
  // pin level keeps tracking while stopped so no stale edge fires at start
  wire trig_edge  = running && (
                    ((edge_sel == edge_rise) && trig_rise) ||
                    ((edge_sel == edge_fall) && trig_fall) ||
                    ((edge_sel == edge_both) && (trig_rise || trig_fall)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_level <= 1'b0;
    end else if (trig_agree) begin
      trig_level <= trig_sync[1];
    end
  end

  // ---------------------------------------------------------------
  // count clock and read hold
  // ---------------------------------------------------------------
  logic [3:0] hold_count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_count <= 4'h0;
    end else if (rd_counter) begin
      hold_count <= 4'(read_hold_cyc);
    end else if (hold_count != 4'h0) begin
      hold_count <= hold_count - 4'h1;
    end
  end

  assign read_hold = rd_counter || (hold_count != 4'h0);

  // divider is cleared while stopped, so the first tick follows the run write by a fixed delay
  count_prescaler u_prescaler (
    .pclk      (pclk),
    .presetn   (presetn),
    .run       (running),
    .hold      (read_hold),
    .clock_sel (prescaler_mode_reg[pos_clock_sel +: 2]),
    .tick      (tick)
  );

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  wire restart      = running && (trig_edge || (soft_trig && oneshot_mode));
  wire period_match = tick && (up_counter == period_compare_reg);
  wire width_match  = tick && (up_counter == width_compare_reg);
  wire overflow     = tick && (up_counter == counter_max);
  wire period_clear = period_mode && period_match;
  wire edge_clear   = edge_mode && trig_edge;
  // zero compares are only reached after an overflow, not right after a clear
  wire zero_step    = tick && zero_armed && (up_counter == 16'h0000);
  wire period_event = (period_compare_reg == 16'h0000) ? zero_step : period_match;
  wire width_event  = (width_compare_reg == 16'h0000) ? zero_step : width_match;
  wire [15:0] next_up_counter = !running ? 16'h0000 :
                                (restart || edge_clear || period_clear) ? 16'h0000 :
                                tick ? up_counter + 16'h0001 : up_counter;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_counter <= 16'h0000;
      zero_armed <= 1'b0;
    end else begin
      up_counter <= next_up_counter;
      if (!running || restart || edge_clear || period_clear) begin
        zero_armed <= 1'b0;
      end else if (overflow) begin
        zero_armed <= 1'b1;
      end else if (tick) begin
        zero_armed <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // output controller
  // ---------------------------------------------------------------
  logic oneshot_active;
  logic out_level;

  wire width_first  = (width_compare_reg < period_compare_reg);
  wire start_event  = width_first ? width_event : period_event;
  wire stop_event   = width_first ? period_event : width_event;
  wire lvl_set      = wr_output && pwdata[pos_output_level_set];
  wire lvl_reset    = wr_output && pwdata[pos_output_level_reset];
  // pulse mode: rise on period clear, fall after width; width + 1 high of period + 1
  wire pulse_toggle = (period_toggle && period_event) || (width_toggle && width_event);
  wire next_level   = lvl_set ? 1'b1 :
                      lvl_reset ? 1'b0 :
                      (!running) ? out_level :
                      oneshot_mode ? ((oneshot_active && start_event) ? 1'b1 :
                                      (stop_event ? 1'b0 : out_level)) :
                      (period_mode && period_event && period_toggle) ? 1'b1 :
                      (period_mode && width_event && width_toggle) ? 1'b0 :
                      pulse_toggle ? !out_level : out_level;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oneshot_active <= 1'b0;
      out_level      <= 1'b0;
    end else begin
      out_level <= next_level;
      if (restart && oneshot_mode) begin
        oneshot_active <= 1'b1;
      end else if (!running || stop_event) begin
        oneshot_active <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_output_pin  <= 1'b0;
      compare_match_irq <= 1'b0;
    end else begin
      pulse_output_pin  <= out_enable && next_level;
      compare_match_irq <= running && (period_event || width_event);
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_compare_reg       <= rst_compare;
      width_compare_reg        <= rst_compare;
      mode_control_reg         <= rst_control;
      capture_compare_ctrl_reg <= rst_control;
      output_control_reg       <= rst_control;
      prescaler_mode_reg       <= rst_control;
    end else begin
      if (wr_period) period_compare_reg <= pwdata[15:0];
      if (wr_width) width_compare_reg <= pwdata[15:0];
      if (wr_capture) capture_compare_ctrl_reg <= pwdata[7:0];
      if (wr_prescale) prescaler_mode_reg <= pwdata[7:0];
      if (wr_output) output_control_reg <= pwdata[7:0] & output_ctrl_read_mask;
      // overflow set wins over a same-cycle clear
      if (wr_mode) begin
        mode_control_reg <= {pwdata[7:1], pwdata[pos_overflow_flag] | overflow};
      end else if (overflow) begin
        mode_control_reg[pos_overflow_flag] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // apb read and answer
  // ---------------------------------------------------------------
  wire [31:0] read_mux = hit(paddr, off_up_counter)      ? {16'h0000, up_counter} :
                         hit(paddr, off_period_compare)  ? {16'h0000, period_compare_reg} :
                         hit(paddr, off_width_compare)   ? {16'h0000, width_compare_reg} :
                         hit(paddr, off_mode_control)    ? {24'h000000, mode_control_reg} :
                         hit(paddr, off_capture_compare) ? {24'h000000, capture_compare_ctrl_reg} :
                         hit(paddr, off_output_control)  ? {24'h000000, output_control_reg} :
                         hit(paddr, off_prescaler_mode)  ? {24'h000000, prescaler_mode_reg} :
                         32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      // answer lands one cycle into the access phase
      pready  <= setup_phase;
      pslverr <= setup_phase && !mapped;
      prdata  <= (setup_phase && !pwrite) ? read_mux : 32'h00000000;
    end
  end
endmodule

// [test/pulse_load_model.sv]
// pulse_load_model: trigger source and pulse output load
// assumes pclk as time base for measuring the output
module pulse_load_model (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pins
  input  wire logic pulse_output_pin,
  output logic      trigger_input_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  int   high_run  = 0;
  int   last_high = 0;
  int   since     = 0;
  int   last_per  = 0;
  int   rises     = 0;
  logic prev_out  = 1'b0;
  initial trigger_input_pin = 1'b0;
  // pin moves off the edge: the source is not clocked
  task automatic set_pin(input logic level);
    @(posedge pclk);
    #7;
    trigger_input_pin = level;
  endtask
  always @(posedge pclk) begin
    prev_out <= pulse_output_pin;
    since    <= since + 1;
    if (pulse_output_pin === 1'b1) high_run <= high_run + 1;
    if (prev_out === 1'b1 && pulse_output_pin !== 1'b1) begin
      last_high <= high_run;
      high_run  <= 0;
    end
    if (prev_out !== 1'b1 && pulse_output_pin === 1'b1) begin
      rises    <= rises + 1;
      last_per <= since;
      since    <= 1;
    end
  end
endmodule

// [test/pulse_timer_monitor.sv]
// pulse_timer_monitor: port checks for the pulse timer
// assumes bind onto timer_pulse_oneshot_output, one clock
module pulse_timer_monitor
  import pulse_timer_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // pins and events
  input wire logic        trigger_input_pin,
  input wire logic        pulse_output_pin,
  input wire logic        compare_match_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // run state, tracked from completed mode writes
  // ----
  logic       running;
  logic [1:0] idle_cnt;
  wire        mode_wr = psel && penable && pready && pwrite && paddr == off_mode_control;
  wire        idle    = idle_cnt == 2'h3;
  wire        rd_done = pready && !pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running  <= 1'b0;
      idle_cnt <= 2'h0;
    end else begin
      if (mode_wr) running <= |pwdata[pos_run_mode_hi:pos_run_mode_lo];
      if (running) idle_cnt <= 2'h0;
      else if (!idle) idle_cnt <= idle_cnt + 2'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  setup_ready_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  ready_once_a: assert property (pready |=> !pready) else $error("ready held too long");
  ready_access_a: assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("ready outside access");
  map_decode_a: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > off_prescaler_mode))
    else $error("wrong error decode");
  err_data_a: assert property (rd_done && pslverr |-> prdata == 32'h0) else $error("error read not zero");
  strobe_zero_a: assert property (
    rd_done && paddr == off_output_control |-> prdata[6] == 1'b0 && prdata[3:2] == 2'h0)
    else $error("strobe bits read back");
  stop_quiet_a: assert property (idle |-> !compare_match_irq) else $error("event while stopped");
  stop_count_a: assert property (
    rd_done && idle && paddr == off_up_counter |-> prdata == 32'h0) else $error("stopped count not zero");
  shot_c: cover property ($rose(pulse_output_pin));
  err_c: cover property (pslverr);
  irq_c: cover property (compare_match_irq);
endmodule

bind timer_pulse_oneshot_output pulse_timer_monitor pulse_timer_monitor_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .trigger_input_pin(trigger_input_pin), .pulse_output_pin(pulse_output_pin),
  .compare_match_irq(compare_match_irq));

// [test/testbench.sv]
// testbench: apb-driven checks of pulse and one-shot output
// assumes pclk at 40 MHz and count clock select 0
module testbench
  import pulse_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        trig;
  logic        pout;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  logic [31:0] first;
  int          err_count   = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  int          irqs        = 0;
  int          base;
  localparam logic [15:0] lo_cmp = 16'h0028;
  localparam logic [15:0] hi_cmp = 16'h002e;
  logic [1:0] edge_tab [3] = '{edge_rise, edge_fall, edge_both};
  logic [1:0] mode_tab [3] = '{run_edge_restart, run_free, run_edge_restart};
  logic       idle_tab [3] = '{1'b0, 1'b1, 1'b0};
  always #12.5 pclk = ~pclk;
  timer_pulse_oneshot_output timer_pulse_oneshot_output_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .trigger_input_pin(trig),
    .pulse_output_pin(pout), .compare_match_irq(irq));
  pulse_load_model pulse_load_model_inst (.pclk(pclk), .presetn(presetn),
    .pulse_output_pin(pout), .trigger_input_pin(trig));
  // ----
  // bus and checking tasks
  // ----
  task automatic results;
    if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // holds the request until ready is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd  = prdata;
    err = pslverr;
    if (n >= 40) err_count++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask
  // compares stay nonzero and apart; control written only while stopped
  task automatic arm(input logic [15:0] n, input logic [15:0] m, input logic [1:0] es,
                     input logic [1:0] mode, input logic lvl);
    wr(off_mode_control, 32'h0);
    pulse_load_model_inst.set_pin(lvl);
    wr(off_width_compare, {16'h0, n});
    wr(off_period_compare, {16'h0, m});
    wr(off_prescaler_mode, {26'h0, es, 4'h0});
    wr(off_output_control, 32'h25);
    wr(off_mode_control, {28'h0, mode, 2'h0});
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (irq === 1'b1) irqs <= irqs + 1;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 24; a += 4) rdchk("reset value", 8'(a), 32'h0);
    bus(1'b0, 8'h1c, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    wr(off_output_control, 32'h76);
    rdchk("output control", off_output_control, 32'h32);
    wr(off_prescaler_mode, {26'h0, edge_both, 4'h0});
    pulse_load_model_inst.set_pin(1'b1);
    pulse_load_model_inst.set_pin(1'b0);
    repeat (8) @(posedge pclk);
    rdchk("stopped count", off_up_counter, 32'h0);
    check("stopped pulses", 32'(pulse_load_model_inst.rises), 32'h0);
    check("stopped events", 32'(irqs), 32'h0);
    wr(off_period_compare, 32'h9);
    wr(off_width_compare, 32'h3);
    wr(off_output_control, 32'h13);
    wr(off_mode_control, {28'h0, run_period_clear, 2'h0});
    repeat (60) @(posedge pclk);
    check("pulse width", 32'(pulse_load_model_inst.last_high), 32'd4);
    check("pulse period", 32'(pulse_load_model_inst.last_per), 32'd10);
    check("match events", {31'h0, irqs > 0}, 32'h1);
    bus(1'b0, off_up_counter, 32'h0);
    check("count bound", {31'h0, rd <= 32'h9}, 32'h1);
    rdchk("width kept", off_width_compare, 32'h3);
    for (int i = 0; i < 2; i++) begin
      arm(i ? hi_cmp : lo_cmp, i ? lo_cmp : hi_cmp, edge_fall, run_free, 1'b0);
      base = pulse_load_model_inst.rises;
      wr(off_output_control, 32'h61);
      repeat (80) @(posedge pclk);
      check("soft width", 32'(pulse_load_model_inst.last_high), 32'd6);
      check("soft count", 32'(pulse_load_model_inst.rises - base), 32'h1);
      bus(1'b0, off_up_counter, 32'h0);
      first = rd;
      bus(1'b0, off_up_counter, 32'h0);
      check("still counting", {31'h0, rd > first}, 32'h1);
    end
    for (int i = 0; i < 3; i++) begin
      arm(lo_cmp, hi_cmp, edge_tab[i], mode_tab[i], idle_tab[i]);
      base = pulse_load_model_inst.rises;
      pulse_load_model_inst.set_pin(!idle_tab[i]);
      repeat (80) @(posedge pclk);
      check("pin width", 32'(pulse_load_model_inst.last_high), 32'd6);
      pulse_load_model_inst.set_pin(idle_tab[i]);
      repeat (80) @(posedge pclk);
      check("pin count", 32'(pulse_load_model_inst.rises - base), (edge_tab[i] == edge_both) ? 32'h2 : 32'h1);
    end
    wr(off_mode_control, 32'h0);
    repeat (4) @(posedge pclk);
    rdchk("count after stop", off_up_counter, 32'h0);
    results();
  end
endmodule
